// >>> swc_params.svh
`ifndef SWC_PARAMS_SVH
`define SWC_PARAMS_SVH

// Trigger mode codes for the external lines
`define SWC_TRIG_RISE  3'h0
`define SWC_TRIG_FALL  3'h1
`define SWC_TRIG_BOTH  3'h2
`define SWC_TRIG_HIGH  3'h3
`define SWC_TRIG_LOW   3'h4
// Standby command codes
`define SWC_CMD_PAUSE  2'h1
`define SWC_CMD_DEEP   2'h2
`define SWC_CMD_XTAL   2'h3
// Reset values
`define SWC_RST_OSC    5'h00
`define SWC_RST_PINS   4'h0
`endif

// >>> swc_pkg.sv
`include "swc_params.svh"
package swc_pkg;
  typedef enum logic [1:0] {
    SWC_RUN, SWC_PAUSE, SWC_DEEP, SWC_XTAL
  } swc_mode_t;

  typedef struct packed {
    swc_mode_t  mode;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_d;
    logic [3:0] line_flag;
    logic [4:0] osc_en;
    logic       reset_wake;
    logic       irq_wake;
  } swc_state_t;
endpackage : swc_pkg

// >>> swc_standby_wakeup_control.sv
`timescale 1ns/1ps
`include "swc_params.svh"
module swc_standby_wakeup_control
  import swc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_mode,
  input  wire logic [4:0] osc_run_req,
  input  wire logic       wdt_lsrc_keep,
  input  wire logic       reset_pin_low,
  input  wire logic       lvd_reset,
  input  wire logic       wdt_reset,
  input  wire logic       irq_accepted,
  input  wire logic       port0_irq,
  input  wire logic       ext_irq_line_e,
  input  wire logic       ext_irq_line_f,
  input  wire logic       base_timer_irq,
  input  wire logic       xtal_selected,
  input  wire logic [3:0] port7_pins,
  input  wire logic [2:0] trig_mode_a,
  input  wire logic [2:0] trig_mode_b,
  input  wire logic [2:0] trig_mode_c,
  input  wire logic [2:0] trig_mode_d,
  input  wire logic [3:0] line_clear,
  output logic            cpu_run,
  output logic            periph_clk_en,
  output logic            base_timer_clk_en,
  output logic [4:0]      osc_en,
  output logic            lsrc_en,
  output logic [3:0]      ext_irq_req,
  output logic            timer_zero_low_byte_capture,
  output logic            port7_pin_a_wake,
  output logic            wake_to_reset,
  output logic            wake_to_irq,
  output swc_mode_t       mode
);
  // osc_en bits: 0 ceramic, 1 low RC, 2 mid RC, 3 var RC, 4 crystal
  swc_state_t st;
  swc_state_t next_st;
  logic [3:0] rise;
  logic [3:0] fall;
  logic [3:0] hit;
  logic [2:0] tm [4];
  logic       any_reset;
  logic       level_ab;
  logic       sleep_wake;

  assign tm[0] = trig_mode_a;
  assign tm[1] = trig_mode_b;
  assign tm[2] = trig_mode_c;
  assign tm[3] = trig_mode_d;
  assign rise = st.pin_s2 & ~st.pin_d;
  assign fall = ~st.pin_s2 & st.pin_d;

  // --------------------------------------------------------------
  // Trigger detection
  // --------------------------------------------------------------
  genvar g;
  for (g = 0; g < 4; g++) begin : g_trig
    if (g < 2) begin : g_ab
      assign hit[g] = (tm[g] == `SWC_TRIG_RISE) ? rise[g] :
                      (tm[g] == `SWC_TRIG_FALL) ? fall[g] :
                      (tm[g] == `SWC_TRIG_HIGH) ? st.pin_s2[g] :
                      (tm[g] == `SWC_TRIG_LOW)  ? ~st.pin_s2[g] : 1'b0;
    end else begin : g_cd
      assign hit[g] = (tm[g] == `SWC_TRIG_RISE) ? rise[g] :
                      (tm[g] == `SWC_TRIG_FALL) ? fall[g] :
                      (tm[g] == `SWC_TRIG_BOTH) ? (rise[g] | fall[g]) :
                      1'b0;
    end
  end

  assign any_reset = reset_pin_low | lvd_reset | wdt_reset;
  assign level_ab =
    (((tm[0] == `SWC_TRIG_HIGH) || (tm[0] == `SWC_TRIG_LOW)) && hit[0]) ||
    (((tm[1] == `SWC_TRIG_HIGH) || (tm[1] == `SWC_TRIG_LOW)) && hit[1]);
  assign sleep_wake = level_ab | hit[2] | ext_irq_line_e |
                      ext_irq_line_f | port0_irq;

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.pin_s1 = port7_pins;
    next_st.pin_s2 = st.pin_s1;
    next_st.pin_d  = st.pin_s2;
    next_st.reset_wake = 1'b0;
    next_st.irq_wake = 1'b0;
    // Set wins over clear
    next_st.line_flag = (st.line_flag & ~line_clear) | hit;
    unique case (st.mode)
      SWC_RUN: begin
        next_st.osc_en = osc_run_req;
        if (cmd_valid) begin
          unique case (cmd_mode)
            `SWC_CMD_PAUSE: next_st.mode = SWC_PAUSE;
            `SWC_CMD_DEEP: begin
              next_st.mode = SWC_DEEP;
              next_st.osc_en = 5'h00;
            end
            `SWC_CMD_XTAL: begin
              next_st.mode = SWC_XTAL;
              next_st.osc_en = {st.osc_en[4], 4'h0};
            end
            default: next_st.mode = SWC_RUN;
          endcase
        end
      end
      SWC_PAUSE: begin
        if (any_reset || irq_accepted || (|hit)) begin
          next_st.mode = SWC_RUN;
          next_st.reset_wake = any_reset;
          next_st.irq_wake = ~any_reset;
        end
      end
      SWC_DEEP, SWC_XTAL: begin
        if (any_reset || sleep_wake || ((st.mode == SWC_XTAL) &&
            base_timer_irq && xtal_selected)) begin
          next_st.mode = SWC_RUN;
          next_st.osc_en = osc_run_req;
          next_st.reset_wake = any_reset;
          next_st.irq_wake = ~any_reset;
        end
      end
    endcase
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st.mode       <= SWC_RUN;
      st.pin_s1     <= `SWC_RST_PINS;
      st.pin_s2     <= `SWC_RST_PINS;
      st.pin_d      <= `SWC_RST_PINS;
      st.line_flag  <= `SWC_RST_PINS;
      st.osc_en     <= `SWC_RST_OSC;
      st.reset_wake <= 1'b0;
      st.irq_wake   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  // core halts in every standby mode; peripherals also stop in deep and crystal modes
  assign cpu_run = (st.mode == SWC_RUN);
  assign periph_clk_en = (st.mode == SWC_RUN) || (st.mode == SWC_PAUSE);
  assign base_timer_clk_en = periph_clk_en || (st.mode == SWC_XTAL);
  assign osc_en = st.osc_en;
  assign lsrc_en = (periph_clk_en & st.osc_en[1]) | wdt_lsrc_keep;
  assign ext_irq_req = st.line_flag;
  assign timer_zero_low_byte_capture = hit[0];
  assign port7_pin_a_wake = hit[0];
  assign wake_to_reset = st.reset_wake;
  assign wake_to_irq = st.irq_wake;
  assign mode = st.mode;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_deep_entry;
    (st.mode == SWC_RUN) && cmd_valid && (cmd_mode == `SWC_CMD_DEEP);
  endsequence
  a_deep_osc_off: assert property (s_deep_entry |=> (osc_en == 5'h00))
    else $error("deep sleep left an oscillator on");
  // Entry itself loads the run request, so hold is judged from then on
  sequence s_pause_stay;
    (mode == SWC_PAUSE) ##1 (mode == SWC_PAUSE);
  endsequence
  a_pause_osc_hold: assert property (s_pause_stay |->
    $stable(osc_en)) else $error("oscillator changed in pause");
  a_pause_reset_exit: assert property ((mode == SWC_PAUSE) &&
    reset_pin_low |=> (mode == SWC_RUN) && wake_to_reset)
    else $error("pause not left on reset");
  a_pause_core_stop: assert property ((mode == SWC_PAUSE) |->
    !cpu_run && periph_clk_en) else $error("pause gating wrong");
  a_deep_periph_off: assert property ((mode == SWC_DEEP) |->
    !periph_clk_en && !base_timer_clk_en) else $error("deep gating wrong");
  a_xtal_keep: assert property ((mode == SWC_XTAL) |->
    $stable(osc_en[4]) && (osc_en[3:0] == 4'h0))
    else $error("crystal state not held");
  a_edge_no_wake: assert property ((mode == SWC_DEEP) &&
    (trig_mode_a == `SWC_TRIG_RISE) && (trig_mode_b == `SWC_TRIG_RISE) &&
    !any_reset && !hit[2] && !ext_irq_line_e && !ext_irq_line_f &&
    !port0_irq |=> (mode == SWC_DEEP)) else $error("edge woke sleep");
  sequence s_bt_event;
    (mode == SWC_XTAL) && base_timer_irq && xtal_selected;
  endsequence
  a_bt_wake: assert property (s_bt_event |=> (mode == SWC_RUN) &&
    (wake_to_irq || wake_to_reset)) else $error("base timer wake missed");
  a_cd_no_level: assert property ((trig_mode_c == `SWC_TRIG_HIGH) |->
    !hit[2]) else $error("line c took level mode");
  a_deep_e_wake: assert property ((mode == SWC_DEEP) &&
    ext_irq_line_e && !any_reset |=> (mode == SWC_RUN) && wake_to_irq)
    else $error("line e did not wake deep sleep");
  a_xtal_gating: assert property ((mode == SWC_XTAL) |->
    !cpu_run && !periph_clk_en && base_timer_clk_en)
    else $error("keepalive gating wrong");
  a_wake_single: assert property (wake_to_irq |=> !wake_to_irq)
    else $error("wake pulse too long");
endmodule : swc_standby_wakeup_control

// >>> swc_core_model.sv
`timescale 1ns/1ps
module swc_core_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic cpu_run,
  input  wire logic irq_pend,
  output logic      irq_accepted
);
  // ----------------------------------------
  // Core side
  // ----------------------------------------
  // accept a pending request while halted
  always_ff @(posedge clk) begin
    if (!rstn) irq_accepted <= 1'b0;
    else irq_accepted <= irq_pend && !cpu_run;
  end
endmodule : swc_core_model

// >>> swc_standby_wakeup_control_tb.sv
`timescale 1ns/1ps
`include "swc_params.svh"
module swc_standby_wakeup_control_tb
  import swc_pkg::*;
;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  logic clk, rstn, cmd_valid, lkeep, pend, irq_acc, bt_irq, xsel, cap, seen;
  logic [1:0] cmd_mode;
  logic [4:0] osc_req, osc_en;
  logic [2:0] rs, ws, trig_a, trig_b, trig_c;
  logic [3:0] pins, clr, req;
  logic       cpu_run, pclk, bclk, lsrc, wake_r, wake_i, pwake;
  swc_mode_t  mode;
  int         error_cnt, checked;
  swc_standby_wakeup_control dut_u (.clk(clk), .rstn(rstn),
    .cmd_valid(cmd_valid), .cmd_mode(cmd_mode), .osc_run_req(osc_req),
    .wdt_lsrc_keep(lkeep), .reset_pin_low(rs[0]), .lvd_reset(rs[1]),
    .wdt_reset(rs[2]), .irq_accepted(irq_acc), .port0_irq(ws[0]),
    .ext_irq_line_e(ws[1]), .ext_irq_line_f(ws[2]),
    .base_timer_irq(bt_irq), .xtal_selected(xsel), .port7_pins(pins),
    .trig_mode_a(trig_a), .trig_mode_b(trig_b), .trig_mode_c(trig_c),
    .trig_mode_d(3'h2), .line_clear(clr), .cpu_run(cpu_run),
    .periph_clk_en(pclk), .base_timer_clk_en(bclk), .osc_en(osc_en),
    .lsrc_en(lsrc), .ext_irq_req(req), .timer_zero_low_byte_capture(cap),
    .port7_pin_a_wake(pwake), .wake_to_reset(wake_r), .wake_to_irq(wake_i),
    .mode(mode));
  swc_core_model core_u (.clk(clk), .rstn(rstn), .cpu_run(cpu_run),
    .irq_pend(pend), .irq_accepted(irq_acc));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic step;
    @(posedge clk);
    #5;
  endtask : step
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic go(input logic [1:0] m);
    cmd_valid = 1;
    cmd_mode = m;
    step;
    cmd_valid = 0;
  endtask : go
  task automatic wait_run;
    seen = 0;
    for (int k = 0; k < 8 && mode !== SWC_RUN; k++) begin
      step;
      seen |= cap;
    end
  endtask : wait_run
  // Every reset source and the port 0, line e and line f deep wakes, with the watchdog keep toggled
  task automatic deep_wakes;
    for (int i = 0; i < 6; i++) begin
      osc_req = 5'h1F;
      lkeep = (i == 1);
      go(2'h2);
      chk(8'(mode), 8'(SWC_DEEP));
      chk(8'({cpu_run, pclk, bclk, osc_en}), 8'h00);
      chk(8'(lsrc), 8'(i == 1));
      {rs, ws} = 6'(1 << i);
      step;
      {rs, ws} = 6'h00;
      chk(8'({mode, wake_r, wake_i}), 8'({SWC_RUN, i > 2, i < 3}));
      chk(8'(osc_en), 8'h1F);
    end
  endtask : deep_wakes
  // Peripherals and clocks run, a second command is ignored
  task automatic pause_wake;
    osc_req = 5'h15;
    go(2'h1);
    chk(8'({cpu_run, pclk, osc_en}), 8'h35);
    step;
    go(2'h2);
    chk(8'(mode), 8'(SWC_PAUSE));
    pend = 1;
    wait_run;
    pend = 0;
    chk(8'({mode, wake_i}), 8'h01);
  endtask : pause_wake
  // Crystal state held from entry, base timer wakes
  task automatic keep_wake;
    osc_req = 5'h1F;
    xsel = 1;
    go(2'h3);
    osc_req = 5'h00;
    step;
    chk(8'({pclk, bclk, osc_en}), 8'h30);
    bt_irq = 1;
    step;
    bt_irq = 0;
    chk(8'({mode, wake_i}), 8'h01);
  endtask : keep_wake
  // Edge mode must not wake, level mode must
  task automatic pin_wake;
    trig_a = `SWC_TRIG_RISE;
    go(2'h2);
    pins = 4'h1;
    repeat (6) step;
    chk(8'(mode), 8'(SWC_DEEP));
    chk(8'(req), 8'h01);
    pins = 4'h0;
    repeat (3) step;
    trig_a = `SWC_TRIG_HIGH;
    pins = 4'h1;
    wait_run;
    chk(8'({mode, seen}), 8'h01);
    chk(8'({cap, pwake}), 8'h03);
    pins = 4'h0;
    clr = 4'hF;
    step;
    chk(8'(req), 8'h01);
    repeat (2) step;
    clr = 4'h0;
    chk(8'(req), 8'h00);
  endtask : pin_wake
  // Line c ignores level mode and wakes on an edge; line d does not wake deep sleep
  task automatic line_cd;
    trig_c = `SWC_TRIG_HIGH;
    go(2'h2);
    pins = 4'hC;
    repeat (4) step;
    chk(8'({mode, req}), 8'h28);
    trig_c = `SWC_TRIG_BOTH;
    pins = 4'h0;
    wait_run;
    chk(8'({mode, wake_r, wake_i}), 8'h01);
    clr = 4'hF;
    step;
    clr = 4'h0;
    chk(8'(req), 8'h00);
  endtask : line_cd
  task automatic end_sim;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    #50000;
    error_cnt++;
    end_sim;
  end
  initial begin
    {rstn, cmd_valid, cmd_mode, lkeep, pend, bt_irq, xsel} = '0;
    {osc_req, rs, ws, pins, clr, error_cnt, checked} = '0;
    trig_a = `SWC_TRIG_RISE;
    trig_b = `SWC_TRIG_RISE;
    trig_c = `SWC_TRIG_RISE;
    repeat (10) step;
    rstn = 1;
    deep_wakes;
    pause_wake;
    keep_wake;
    pin_wake;
    line_cd;
    end_sim;
  end
endmodule : swc_standby_wakeup_control_tb
